// [mag_detect.sv]
// magnetic vehicle detector: baseline, deviation, qualification and register port
//
// Overview of operation
// - writing one to the capture register latches each axis's ambient reading as baseline
// - baseline is kept separately for x, y and z
// - detection value rises with the size of deviation from baseline
// - axis disable mask: bit 0 x, bit 1 y, bit 2 z; one excludes axis
// - writing one to compensation median off bypasses that median filter
// - writing one to sensing median off bypasses that median filter
// - tau select takes 0 to 6, zero weakest and six strongest smoothing
// - nonzero high count needs that many consecutive above-threshold samples; zero disables
// - nonzero low count needs that many consecutive low samples; zero disables
// - reading above threshold sets detection register bit 0
// - reading below threshold minus hysteresis clears detection register bit 0
// - threshold and hysteresis are full 16-bit unsigned settings
// - threshold resets to 150, hysteresis to 30
// - with drift tracking on and low readings, baseline creeps toward ambient
// - drift time sets tracking rate; drift threshold gates when it runs
// - total deviation combines the per-axis differences from baseline
`timescale 1ns/1ps
module mag_detect #(
  parameter int W = mag_detect_pkg::DATA_W
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic sample_valid,
  input wire logic signed [W-1:0] field_x,
  input wire logic signed [W-1:0] field_y,
  input wire logic signed [W-1:0] field_z,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  output logic detect_on,
  output logic [15:0] detect_value,
  output logic [15:0] deviation_total,
  output logic update_valid
);
  import mag_detect_pkg::*;

  logic [AXES-1:0] axis_off_r;
  logic comp_med_off_r, sens_med_off_r;
  logic [TAU_W-1:0] tau_r;
  logic [QUAL_W-1:0] high_qual_r, low_qual_r, high_cnt_r, low_cnt_r;
  logic [15:0] delta_r, thr_r, hyst_r, drift_time_r, drift_thr_r, drift_cnt_r;
  logic signed [W-1:0] base_r [AXES];
  logic [15:0] dev_r [AXES];
  logic signed [W-1:0] raw [AXES];
  logic signed [W-1:0] sens [AXES];
  logic signed [W-1:0] comp [AXES];
  logic [AXES-1:0] cond_valid;
  logic [15:0] dev_m [AXES];
  logic [17:0] sum_wide;
  logic [15:0] total_nxt, off_point, change;
  logic [15:0] total_r, reported_r;
  logic detect_r;
  logic above, below_off, capture, drift_go, drift_step;

  assign raw[AXIS_X] = field_x;
  assign raw[AXIS_Y] = field_y;
  assign raw[AXIS_Z] = field_z;
  assign capture = reg_wr && reg_addr == ADDR_BASELINE_CAPTURE && reg_wdata == CMD_ONE;

  genvar g;
  generate
    for (g = 0; g < AXES; g++) begin : gen_axis
      logic signed [W:0] diff;
      logic [W:0] mag;
      axis_conditioner #(.W(W)) u_cond (
        .sys_clk(sys_clk),
        .srst(srst),
        .sample_valid(sample_valid),
        .sample(raw[g]),
        .sens_med_off(sens_med_off_r),
        .comp_med_off(comp_med_off_r),
        .tau_sel(tau_r),
        .sens_out(sens[g]),
        .comp_out(comp[g]),
        .out_valid(cond_valid[g])
      );
      assign diff = (W+1)'(sens[g]) - (W+1)'(base_r[g]);
      assign mag = diff[W] ? (W+1)'(-diff) : (W+1)'(diff);
      // masked axis contributes nothing; per-axis value clipped to 16 bits
      assign dev_m[g] = axis_off_r[g] ? ZERO16 : (mag[W] ? MAX16 : mag[15:0]);

      always_ff @(posedge sys_clk) begin
        if (srst) begin
          base_r[g] <= '0;
          dev_r[g] <= ZERO16;
        end else begin
          if (cond_valid[0]) begin
            dev_r[g] <= dev_m[g];
          end
          // capture wins over a drift step in the same cycle
          if (capture) begin
            base_r[g] <= comp[g];
          end else if (drift_step && comp[g] > base_r[g]) begin
            base_r[g] <= base_r[g] + W'(1);
          end else if (drift_step && comp[g] < base_r[g]) begin
            base_r[g] <= base_r[g] - W'(1);
          end
        end
      end
    end
  endgenerate

  assign sum_wide = 18'(dev_m[AXIS_X]) + 18'(dev_m[AXIS_Y]) + 18'(dev_m[AXIS_Z]);
  assign total_nxt = (sum_wide > 18'(MAX16)) ? MAX16 : sum_wide[15:0];
  assign off_point = (hyst_r > thr_r) ? ZERO16 : thr_r - hyst_r;
  assign above = total_nxt > thr_r;
  assign below_off = total_nxt < off_point;
  assign change = (total_nxt > reported_r) ? total_nxt - reported_r : reported_r - total_nxt;
  assign drift_go = cond_valid[0] && drift_time_r != ZERO16 && total_nxt < drift_thr_r;
  assign drift_step = drift_go && (drift_cnt_r + 16'h0001) >= drift_time_r;

  // configuration writes
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      axis_off_r <= MASK_RESET;
      comp_med_off_r <= 1'b0;
      sens_med_off_r <= 1'b0;
      tau_r <= WEAKEST_SMOOTHING_LEVEL;
      high_qual_r <= QUAL_RESET;
      low_qual_r <= QUAL_RESET;
      delta_r <= ZERO16;
      thr_r <= THRESHOLD_RESET;
      hyst_r <= HYSTERESIS_RESET;
      drift_time_r <= ZERO16;
      drift_thr_r <= ZERO16;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_AXIS_DISABLE_MASK: axis_off_r <= reg_wdata[AXES-1:0];
        ADDR_COMPENSATION_MEDIAN_OFF: comp_med_off_r <= reg_wdata == CMD_ONE;
        ADDR_SENSING_MEDIAN_OFF: sens_med_off_r <= reg_wdata == CMD_ONE;
        ADDR_TAU_FILTER_SELECT: begin
          // out-of-range selections clamp to the strongest setting
          if (reg_wdata > 16'(STRONGEST_SMOOTHING_LEVEL)) begin
            tau_r <= STRONGEST_SMOOTHING_LEVEL;
          end else begin
            tau_r <= reg_wdata[TAU_W-1:0];
          end
        end
        ADDR_ACTIVE_QUALIFY_COUNT: high_qual_r <= reg_wdata[QUAL_W-1:0];
        ADDR_INACTIVE_QUALIFY_COUNT: low_qual_r <= reg_wdata[QUAL_W-1:0];
        ADDR_RATE_OF_CHANGE_FILTER: delta_r <= reg_wdata;
        ADDR_DETECT_THRESHOLD: thr_r <= reg_wdata;
        ADDR_DETECT_HYSTERESIS: hyst_r <= reg_wdata;
        ADDR_DRIFT_FILTER_TIME: drift_time_r <= reg_wdata;
        ADDR_DRIFT_FILTER_THRESHOLD: drift_thr_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // drift pacing: counts quiet samples between single-lsb baseline steps
  always_ff @(posedge sys_clk) begin
    if (srst || capture) begin
      drift_cnt_r <= ZERO16;
    end else if (cond_valid[0]) begin
      if (!drift_go || drift_step) begin
        drift_cnt_r <= ZERO16;
      end else begin
        drift_cnt_r <= drift_cnt_r + 16'h0001;
      end
    end
  end

  // consecutive-sample qualification and threshold/hysteresis state
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      high_cnt_r <= QUAL_RESET;
      low_cnt_r <= QUAL_RESET;
      detect_r <= 1'b0;
    end else if (cond_valid[0]) begin
      if (above) begin
        low_cnt_r <= QUAL_RESET;
        high_cnt_r <= (high_cnt_r == QUAL_MAX) ? QUAL_MAX : high_cnt_r + 8'h01;
        if (high_qual_r == QUAL_RESET || high_cnt_r + 8'h01 >= high_qual_r) begin
          detect_r <= 1'b1;
        end
      end else if (below_off) begin
        high_cnt_r <= QUAL_RESET;
        low_cnt_r <= (low_cnt_r == QUAL_MAX) ? QUAL_MAX : low_cnt_r + 8'h01;
        if (low_qual_r == QUAL_RESET || low_cnt_r + 8'h01 >= low_qual_r) begin
          detect_r <= 1'b0;
        end
      end else begin
        // inside the hysteresis band both runs are broken
        high_cnt_r <= QUAL_RESET;
        low_cnt_r <= QUAL_RESET;
      end
    end
  end

  // total always tracks; reported value moves only once the change reaches the delta step
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      total_r <= ZERO16;
      reported_r <= ZERO16;
      update_valid <= 1'b0;
    end else begin
      update_valid <= cond_valid[0];
      if (cond_valid[0]) begin
        total_r <= total_nxt;
        if (delta_r == ZERO16 || change >= delta_r) begin
          reported_r <= total_nxt;
        end
      end
    end
  end

  assign detect_on = detect_r;
  assign deviation_total = total_r;
  assign detect_value = {reported_r[15:1], detect_r};

  // read port: one-cycle latency, unmapped and write-only addresses read zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= ZERO16;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          ADDR_AXIS_DISABLE_MASK: reg_rdata <= 16'(axis_off_r);
          ADDR_COMPENSATION_MEDIAN_OFF: reg_rdata <= 16'(comp_med_off_r);
          ADDR_SENSING_MEDIAN_OFF: reg_rdata <= 16'(sens_med_off_r);
          ADDR_TAU_FILTER_SELECT: reg_rdata <= 16'(tau_r);
          ADDR_ACTIVE_QUALIFY_COUNT: reg_rdata <= 16'(high_qual_r);
          ADDR_INACTIVE_QUALIFY_COUNT: reg_rdata <= 16'(low_qual_r);
          ADDR_RATE_OF_CHANGE_FILTER: reg_rdata <= delta_r;
          ADDR_DETECT_THRESHOLD: reg_rdata <= thr_r;
          ADDR_DETECT_HYSTERESIS: reg_rdata <= hyst_r;
          ADDR_DRIFT_FILTER_TIME: reg_rdata <= drift_time_r;
          ADDR_DRIFT_FILTER_THRESHOLD: reg_rdata <= drift_thr_r;
          ADDR_DETECT_STATUS: reg_rdata <= detect_value;
          ADDR_DEVIATION_TOTAL: reg_rdata <= total_r;
          ADDR_DEVIATION_X: reg_rdata <= dev_r[AXIS_X];
          ADDR_DEVIATION_X + 16'h0001: reg_rdata <= dev_r[AXIS_Y];
          ADDR_DEVIATION_X + 16'h0002: reg_rdata <= dev_r[AXIS_Z];
          ADDR_BASELINE_X: reg_rdata <= base_r[AXIS_X];
          ADDR_BASELINE_X + 16'h0001: reg_rdata <= base_r[AXIS_Y];
          ADDR_BASELINE_X + 16'h0002: reg_rdata <= base_r[AXIS_Z];
          ADDR_RAW_X: reg_rdata <= sens[AXIS_X];
          ADDR_RAW_X + 16'h0001: reg_rdata <= sens[AXIS_Y];
          ADDR_RAW_X + 16'h0002: reg_rdata <= sens[AXIS_Z];
          default: reg_rdata <= ZERO16;
        endcase
      end
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  capture_load_a: assert property (capture |=> base_r[AXIS_Y] == $past(comp[AXIS_Y]))
    else $error("baseline not captured");
  per_axis_base_a: assert property (capture |=> base_r[AXIS_Z] == $past(comp[AXIS_Z]))
    else $error("z baseline not captured");
  total_covers_a: assert property (cond_valid[0] |=> total_r >= $past(dev_m[AXIS_X]))
    else $error("total below x deviation");
  mask_zero_a: assert property (cond_valid[0] && axis_off_r == 3'h7 |=> total_r == ZERO16)
    else $error("masked axes contributed");
  mask_write_a: assert property (reg_wr && reg_addr == ADDR_AXIS_DISABLE_MASK |=>
    axis_off_r == $past(reg_wdata[AXES-1:0]))
    else $error("axis mask not stored");
  tau_range_a: assert property (tau_r <= STRONGEST_SMOOTHING_LEVEL)
    else $error("tau select out of range");
  high_direct_a: assert property (cond_valid[0] && above && high_qual_r == QUAL_RESET
    |=> detect_r)
    else $error("detect not set without qualification");
  rise_cause_a: assert property ($rose(detect_r) |-> $past(above && cond_valid[0]))
    else $error("detect rose without high reading");
  fall_cause_a: assert property ($fell(detect_r) |-> $past(below_off && cond_valid[0]))
    else $error("detect fell without low reading");
  low_direct_a: assert property (cond_valid[0] && below_off && low_qual_r == QUAL_RESET
    |=> !detect_r)
    else $error("detect not cleared without qualification");
  reset_values_a: assert property ($fell(srst) |-> thr_r == THRESHOLD_RESET
    && hyst_r == HYSTERESIS_RESET)
    else $error("threshold or hysteresis reset wrong");
  read_answer_a: assert property (reg_rd |=> reg_rvalid ##1 !reg_rvalid || $past(reg_rd))
    else $error("read answer missing");
  drift_gate_a: assert property (drift_step |-> total_nxt < drift_thr_r
    && drift_time_r != ZERO16)
    else $error("drift step outside quiet window");
endmodule

// [mag_detect_pkg.sv]
// shared register map, reset values and widths for the magnetic detector
package mag_detect_pkg;
  localparam int DATA_W = 16;
  localparam int AXES = 3;
  localparam int AXIS_X = 0;
  localparam int AXIS_Y = 1;
  localparam int AXIS_Z = 2;
  localparam int QUAL_W = 8;
  localparam int TAU_W = 3;
  localparam int TAU_FRAC = 6;

  localparam logic [15:0] ADDR_BASELINE_CAPTURE = 16'h1195;
  localparam logic [15:0] ADDR_AXIS_DISABLE_MASK = 16'h1196;
  localparam logic [15:0] ADDR_COMPENSATION_MEDIAN_OFF = 16'h1197;
  localparam logic [15:0] ADDR_SENSING_MEDIAN_OFF = 16'h1198;
  localparam logic [15:0] ADDR_TAU_FILTER_SELECT = 16'h1199;
  localparam logic [15:0] ADDR_ACTIVE_QUALIFY_COUNT = 16'h119A;
  localparam logic [15:0] ADDR_INACTIVE_QUALIFY_COUNT = 16'h119B;
  localparam logic [15:0] ADDR_RATE_OF_CHANGE_FILTER = 16'h119D;
  localparam logic [15:0] ADDR_DETECT_THRESHOLD = 16'h119E;
  localparam logic [15:0] ADDR_DETECT_HYSTERESIS = 16'h119F;
  localparam logic [15:0] ADDR_DRIFT_FILTER_TIME = 16'h11A0;
  localparam logic [15:0] ADDR_DRIFT_FILTER_THRESHOLD = 16'h11A1;
  localparam logic [15:0] ADDR_DETECT_STATUS = 16'h11A8;
  localparam logic [15:0] ADDR_DEVIATION_TOTAL = 16'h11A9;
  localparam logic [15:0] ADDR_DEVIATION_X = 16'h11AA;
  localparam logic [15:0] ADDR_BASELINE_X = 16'h11AD;
  localparam logic [15:0] ADDR_RAW_X = 16'h11B0;

  localparam logic [15:0] CMD_ONE = 16'h0001;
  localparam logic [15:0] THRESHOLD_RESET = 16'h0096;
  localparam logic [15:0] HYSTERESIS_RESET = 16'h001E;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [15:0] MAX16 = 16'hFFFF;
  localparam logic [2:0] WEAKEST_SMOOTHING_LEVEL = 3'h0;
  localparam logic [2:0] STRONGEST_SMOOTHING_LEVEL = 3'h6;
  localparam logic [2:0] MASK_RESET = 3'h0;
  localparam logic [7:0] QUAL_RESET = 8'h00;
  localparam logic [7:0] QUAL_MAX = 8'hFF;
endpackage

// [axis_conditioner.sv]
// one axis: 3-tap median with bypasses and a shift-based tau low-pass
`timescale 1ns/1ps
module axis_conditioner #(
  parameter int W = 16
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic sample_valid,
  input wire logic signed [W-1:0] sample,
  input wire logic sens_med_off,
  input wire logic comp_med_off,
  input wire logic [mag_detect_pkg::TAU_W-1:0] tau_sel,
  output logic signed [W-1:0] sens_out,
  output logic signed [W-1:0] comp_out,
  output logic out_valid
);
  import mag_detect_pkg::*;
  localparam int AW = W + TAU_FRAC + 2;
  logic signed [W-1:0] hist1_r, hist2_r, med, sens_in;
  logic signed [AW-1:0] acc_r, acc_nxt, target, step;

  always_comb begin
    if ((sample >= hist1_r) == (sample <= hist2_r)) begin
      med = sample;
    end else if ((hist1_r >= sample) == (hist1_r <= hist2_r)) begin
      med = hist1_r;
    end else begin
      med = hist2_r;
    end
  end

  // each path picks median or raw on its own
  assign sens_in = sens_med_off ? sample : med;
  // tau 0 makes the accumulator follow the input exactly
  assign target = AW'(sens_in) <<< TAU_FRAC;
  assign step = (target - acc_r) >>> tau_sel;
  assign acc_nxt = acc_r + step;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      hist1_r <= '0;
      hist2_r <= '0;
    end else if (sample_valid) begin
      hist1_r <= sample;
      hist2_r <= hist1_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      acc_r <= '0;
      sens_out <= '0;
      comp_out <= '0;
      out_valid <= 1'b0;
    end else begin
      out_valid <= sample_valid;
      if (sample_valid) begin
        acc_r <= acc_nxt;
        sens_out <= W'(acc_nxt >>> TAU_FRAC);
        comp_out <= comp_med_off ? sample : med;
      end
    end
  end
endmodule

// [mag_element_model.sv]
// behavioural three-axis field element that feeds readings to the detector
`timescale 1ns/1ps
module mag_element_model (
  input wire logic sys_clk,
  input wire logic req,
  input wire logic signed [15:0] req_x,
  input wire logic signed [15:0] req_y,
  input wire logic signed [15:0] req_z,
  output logic sample_valid,
  output logic signed [15:0] field_x,
  output logic signed [15:0] field_y,
  output logic signed [15:0] field_z
);
  initial begin
    sample_valid = 1'b0;
    field_x = 16'h0000;
    field_y = 16'h0000;
    field_z = 16'h0000;
  end
  // readings only mean something with the strobe; scramble them otherwise
  // so a design that samples stale lines cannot pass by luck
  always @(posedge sys_clk) begin
    sample_valid <= req;
    if (req) begin
      field_x <= req_x;
      field_y <= req_y;
      field_z <= req_z;
    end else begin
      field_x <= ~field_x;
      field_y <= ~field_y;
      field_z <= ~field_z;
    end
  end
endmodule

// [test_mag_detect.sv]
// self-checking bench for the magnetic detector register port and sample path
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin err_total++; \
  $display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); end end
module test_mag_detect;
  import mag_detect_pkg::*;
  logic sys_clk, srst, req, sample_valid, reg_wr, reg_rd, reg_rvalid, detect_on, update_valid;
  logic signed [15:0] rx, ry, rz, field_x, field_y, field_z;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, detect_value, deviation_total, ex;
  int err_total = 0;
  int tests_run = 0;
  logic [15:0] dv [5] = '{16'h0096, 16'h0097, 16'h0079, 16'h0078, 16'h0077};
  logic onb [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
  logic [15:0] base [3] = '{16'h0064, 16'h00C8, 16'h012C};

  mag_element_model far (.sys_clk(sys_clk), .req(req), .req_x(rx), .req_y(ry), .req_z(rz),
    .sample_valid(sample_valid), .field_x(field_x), .field_y(field_y), .field_z(field_z));
  mag_detect dut (.sys_clk(sys_clk), .srst(srst), .sample_valid(sample_valid),
    .field_x(field_x), .field_y(field_y), .field_z(field_z), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .detect_on(detect_on), .detect_value(detect_value),
    .deviation_total(deviation_total), .update_valid(update_valid));

  always #5 sys_clk = ~sys_clk;

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rvalid, 1'b1)
    `CHK(reg_rdata, e)
  endtask

  // bounded wait: the update is due two edges after the sample is taken
  task automatic samp(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
    int n;
    n = 0;
    @(posedge sys_clk);
    req <= 1'b1;
    rx <= x;
    ry <= y;
    rz <= z;
    @(posedge sys_clk);
    req <= 1'b0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (update_valid !== 1'b1 && n < 10);
    `CHK(update_valid, 1'b1)
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #500000;
    err_total++;
    conclude();
  end

  initial begin
    sys_clk = 1'b0;
    srst = 1'b1;
    req = 1'b0;
    rx = 16'h0000;
    ry = 16'h0000;
    rz = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    rdchk(ADDR_DETECT_THRESHOLD, THRESHOLD_RESET);
    rdchk(ADDR_DETECT_HYSTERESIS, HYSTERESIS_RESET);
    rdchk(ADDR_ACTIVE_QUALIFY_COUNT, ZERO16);
    rdchk(ADDR_INACTIVE_QUALIFY_COUNT, ZERO16);
    rdchk(ADDR_BASELINE_CAPTURE, ZERO16);
    rdchk(16'h119C, ZERO16);
    wr(ADDR_DETECT_THRESHOLD, MAX16);
    rdchk(ADDR_DETECT_THRESHOLD, MAX16);
    wr(ADDR_DETECT_HYSTERESIS, MAX16);
    rdchk(ADDR_DETECT_HYSTERESIS, MAX16);
    wr(ADDR_DETECT_THRESHOLD, THRESHOLD_RESET);
    wr(ADDR_DETECT_HYSTERESIS, HYSTERESIS_RESET);
    wr(ADDR_TAU_FILTER_SELECT, 16'h0007);
    rdchk(ADDR_TAU_FILTER_SELECT, 16'h0006);
    // raw paths first, so every expectation is plain arithmetic
    wr(ADDR_COMPENSATION_MEDIAN_OFF, CMD_ONE);
    wr(ADDR_SENSING_MEDIAN_OFF, CMD_ONE);
    rdchk(ADDR_COMPENSATION_MEDIAN_OFF, CMD_ONE);
    rdchk(ADDR_SENSING_MEDIAN_OFF, CMD_ONE);
    wr(ADDR_TAU_FILTER_SELECT, 16'h0000);
    samp(base[0], base[1], base[2]);
    wr(ADDR_BASELINE_CAPTURE, CMD_ONE);
    for (int i = 0; i < 3; i++) rdchk(ADDR_BASELINE_X + i[15:0], base[i]);
    for (int m = 0; m < 8; m++) begin
      wr(ADDR_AXIS_DISABLE_MASK, m[15:0]);
      rdchk(ADDR_AXIS_DISABLE_MASK, m[15:0]);
      samp(16'h0096, 16'h00E6, 16'h0154);
      ex = (m[0] ? 16'h0000 : 16'h0032) + (m[1] ? 16'h0000 : 16'h001E)
        + (m[2] ? 16'h0000 : 16'h0028);
      `CHK(deviation_total, ex)
    end
    wr(ADDR_AXIS_DISABLE_MASK, 16'h0000);
    for (int k = 0; k < 5; k++) begin
      samp(base[0] + dv[k], base[1], base[2]);
      `CHK(detect_on, onb[k])
      `CHK(detect_value, {dv[k][15:1], onb[k]})
      `CHK(deviation_total, dv[k])
    end
    rdchk(ADDR_DETECT_STATUS, 16'h0076);
    wr(ADDR_ACTIVE_QUALIFY_COUNT, 16'h0003);
    wr(ADDR_INACTIVE_QUALIFY_COUNT, 16'h0002);
    for (int k = 0; k < 3; k++) begin
      samp(16'h012C, base[1], base[2]);
      `CHK(detect_on, (k == 2))
    end
    for (int k = 0; k < 2; k++) begin
      samp(base[0], base[1], base[2]);
      `CHK(detect_on, (k == 0))
    end
    wr(ADDR_ACTIVE_QUALIFY_COUNT, 16'h0000);
    wr(ADDR_INACTIVE_QUALIFY_COUNT, 16'h0000);
    samp(16'h7FFF, 16'h8000, base[2]);
    `CHK(deviation_total, MAX16)
    rdchk(ADDR_DEVIATION_TOTAL, MAX16);
    samp(base[0], base[1], base[2]);
    wr(ADDR_TAU_FILTER_SELECT, 16'h0001);
    samp(16'h00C8, base[1], base[2]);
    `CHK(deviation_total, 16'h0032)
    rdchk(ADDR_RAW_X, 16'h0096);
    rdchk(ADDR_DEVIATION_X, 16'h0032);
    wr(ADDR_TAU_FILTER_SELECT, 16'h0000);
    samp(base[0], base[1], base[2]);
    // spike on x: median of 100, 100, 5000 keeps 100
    // compensation median must be on before the spike: its output is latched per sample
    wr(ADDR_SENSING_MEDIAN_OFF, 16'h0000);
    wr(ADDR_COMPENSATION_MEDIAN_OFF, 16'h0000);
    samp(base[0], base[1], base[2]);
    samp(16'h1388, base[1], base[2]);
    `CHK(deviation_total, 16'h0000)
    wr(ADDR_SENSING_MEDIAN_OFF, CMD_ONE);
    wr(ADDR_BASELINE_CAPTURE, CMD_ONE);
    rdchk(ADDR_BASELINE_X, base[0]);
    samp(16'h1388, base[1], base[2]);
    `CHK(deviation_total, 16'h1324)
    // raw 100 now; the median of 100, 5000, 5000 would give 5000
    wr(ADDR_COMPENSATION_MEDIAN_OFF, CMD_ONE);
    samp(base[0], base[1], base[2]);
    wr(ADDR_BASELINE_CAPTURE, CMD_ONE);
    rdchk(ADDR_BASELINE_X, base[0]);
    wr(ADDR_DRIFT_FILTER_THRESHOLD, 16'h0032);
    wr(ADDR_DRIFT_FILTER_TIME, 16'h0002);
    rdchk(ADDR_DRIFT_FILTER_TIME, 16'h0002);
    rdchk(ADDR_DRIFT_FILTER_THRESHOLD, 16'h0032);
    repeat (4) samp(16'h006E, base[1], base[2]);
    rdchk(ADDR_BASELINE_X, 16'h0066);
    rdchk(ADDR_BASELINE_X + 16'h0001, base[1]);
    wr(ADDR_DRIFT_FILTER_TIME, 16'h0000);
    // delta gates only the reported value; x baseline has crept to 102, last report 9
    wr(ADDR_RATE_OF_CHANGE_FILTER, 16'h0064);
    rdchk(ADDR_RATE_OF_CHANGE_FILTER, 16'h0064);
    samp(16'h0096, base[1], base[2]);
    `CHK(deviation_total, 16'h0030)
    `CHK(detect_value, 16'h0008)
    samp(16'h01F4, base[1], base[2]);
    `CHK(detect_value, 16'h018F)
    conclude();
  end
endmodule
